// ### pmc_priv_ctrl.sv
/*
  Privilege mode control: current level, debug tier, privileged instruction
  checks, traps and returns, and atomic control register access.
  Assumes instruction issue and debug request come from logic on mclk.
*/
`timescale 1ns/1ns
`default_nettype none
module pmc_priv_ctrl (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Instruction issue
  input wire logic instr_valid,
  input wire logic [31:0] instr,
  input wire logic [31:0] instr_pc,
  input wire logic [31:0] rs1_data,
  // Debug entry
  input wire logic dbg_req,
  // Level and status
  output logic [1:0] priv_q,
  output logic dbg_mode_q,
  output logic busy_q,
  // Exception report
  output logic exc_valid_q,
  output logic [3:0] exc_cause_q,
  // Control flow redirect
  output logic redirect_valid_q,
  output logic [31:0] redirect_pc_q,
  // Register read result
  output logic rd_valid_q,
  output logic [31:0] rd_data_q
);
  pmc_pkg::pmc_state_t state_q;
  logic [1:0] prev_q;
  logic [31:0] epc_q, dpc_q, cycle_q;
  logic [2:0] s_sel_q, s_f3_q;
  logic [31:0] s_src_q;
  logic s_wr_q;
  logic [31:0] store_rd;

  logic [2:0] f3;
  logic [11:0] addr;
  logic [3:0] map;
  logic is_sys, dbg_take, go, is_csr, csr_wr, dbg_only, csr_ro_wr;
  logic csr_priv_ok, csr_bad;
  logic ill, ecall, brk, ret_top, ret_ker, ret_dbg, csr_go, trap;
  logic [3:0] cause;
  logic [31:0] old_val, new_val;
  logic do_wr;

  // Existence and selector for a register address; only built levels count
  function automatic logic [3:0] csr_map(input logic [11:0] a);
    logic [2:0] sel;
    logic hit;
    hit = 1'b1;
    sel = 3'h0;
    unique case (a)
      pmc_pkg::CSR_APP_SCRATCH: sel = 3'h0;
      pmc_pkg::CSR_KER_SCRATCH: sel = 3'h1;
      pmc_pkg::CSR_TOP_SCRATCH: sel = 3'h2;
      pmc_pkg::CSR_DBG_SCRATCH: begin
        sel = 3'h3;
        hit = pmc_pkg::DEBUG_IMPL;
      end
      pmc_pkg::CSR_TOP_STATUS: sel = pmc_pkg::SEL_STATUS;
      pmc_pkg::CSR_TOP_EPC: sel = pmc_pkg::SEL_EPC;
      pmc_pkg::CSR_CYCLE: sel = pmc_pkg::SEL_CYCLE;
      pmc_pkg::CSR_HART_ID: sel = pmc_pkg::SEL_HART;
      default: hit = 1'b0;
    endcase
    csr_map = {hit & pmc_pkg::pmc_legal(a[9:8]), sel};
  endfunction : csr_map

  assign f3 = instr[14:12];
  assign addr = instr[31:20];
  assign map = csr_map(addr);
  assign is_sys = (instr[6:0] == pmc_pkg::OPC_SYSTEM);
  assign dbg_take = pmc_pkg::DEBUG_IMPL && dbg_req && !dbg_mode_q &&
                    (state_q == pmc_pkg::ST_IDLE);
  // Debug entry wins; the instruction in that cycle is refused
  assign go = instr_valid && is_sys && !dbg_take &&
              (state_q == pmc_pkg::ST_IDLE);
  assign is_csr = (f3 != pmc_pkg::F3_PRIV) && (f3 != pmc_pkg::F3_RSV);
  assign csr_wr = (f3[1:0] == pmc_pkg::F3_LOW_RW) || (instr[19:15] != 5'h0);
  assign dbg_only = (addr >= pmc_pkg::DBG_ONLY_LO) &&
                    (addr <= pmc_pkg::DBG_ONLY_HI);
  // Unsigned compare works since the reserved code is never held
  assign csr_priv_ok = dbg_mode_q || (priv_q >= addr[9:8]);
  assign csr_ro_wr = (addr[11:10] == pmc_pkg::RO_CODE) && csr_wr;
  assign csr_bad = !map[3] || !csr_priv_ok || csr_ro_wr ||
                   (dbg_only && !dbg_mode_q);

  always_comb begin
    ill = 1'b0;
    ecall = 1'b0;
    brk = 1'b0;
    ret_top = 1'b0;
    ret_ker = 1'b0;
    ret_dbg = 1'b0;
    csr_go = 1'b0;
    if (go) begin
      if (is_csr) begin
        ill = csr_bad;
        csr_go = !csr_bad;
      end else if (instr == pmc_pkg::INS_ENV_CALL) begin
        ecall = 1'b1;
      end else if (instr == pmc_pkg::INS_BREAK) begin
        brk = 1'b1;
      end else if (instr == pmc_pkg::INS_TOP_RET) begin
        ret_top = (priv_q == pmc_pkg::PRV_TOP) || dbg_mode_q;
        ill = !ret_top;
      end else if (instr == pmc_pkg::INS_KER_RET) begin
        ret_ker = (pmc_pkg::LVL_CFG == pmc_pkg::CFG_TOP_KER_APP) &&
                  ((priv_q != pmc_pkg::PRV_APP) || dbg_mode_q);
        ill = !ret_ker;
      end else if (instr == pmc_pkg::INS_WAIT) begin
        ill = (priv_q == pmc_pkg::PRV_APP) && !dbg_mode_q;
      end else if (instr == pmc_pkg::INS_DBG_RET) begin
        ret_dbg = dbg_mode_q;
        ill = !dbg_mode_q;
      end else begin
        ill = 1'b1;
      end
    end
  end

  assign trap = ill || ecall || brk;
  assign cause = ill ? pmc_pkg::CAUSE_ILLEGAL :
                 brk ? pmc_pkg::CAUSE_BREAK :
                 pmc_pkg::CAUSE_ECALL_BASE + {2'h0, priv_q};

  // Second half of the atomic access: old value in, new value out
  always_comb begin
    unique case (s_sel_q)
      pmc_pkg::SEL_STATUS: begin
        old_val = 32'h0;
        old_val[pmc_pkg::STAT_PREV_HI:pmc_pkg::STAT_PREV_LO] = prev_q;
      end
      pmc_pkg::SEL_EPC: old_val = epc_q;
      pmc_pkg::SEL_CYCLE: old_val = cycle_q;
      pmc_pkg::SEL_HART: old_val = pmc_pkg::HART_ID_VAL;
      default: old_val = store_rd;
    endcase
    if (s_f3_q[1:0] == pmc_pkg::F3_LOW_RW) begin
      new_val = s_src_q;
    end else if (s_f3_q[1:0] == pmc_pkg::F3_LOW_RS) begin
      new_val = old_val | s_src_q;
    end else begin
      new_val = old_val & ~s_src_q;
    end
  end

  assign do_wr = (state_q == pmc_pkg::ST_RMW) && s_wr_q;

  pmc_csr_store u_store (
    .mclk(mclk),
    .rst(rst),
    .wr_en(do_wr && !s_sel_q[2]),
    .wr_idx(s_sel_q[1:0]),
    .wr_data(new_val),
    .rd_en(csr_go),
    .rd_idx(map[1:0]),
    .rd_data(store_rd)
  );

  // No other access can slip between read and write while busy
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= pmc_pkg::ST_IDLE;
      busy_q <= 1'b0;
    end else begin
      unique case (state_q)
        pmc_pkg::ST_IDLE: if (csr_go) state_q <= pmc_pkg::ST_RMW;
        pmc_pkg::ST_RMW: state_q <= pmc_pkg::ST_IDLE;
      endcase
      busy_q <= csr_go;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_sel_q <= 3'h0;
      s_f3_q <= 3'h0;
      s_src_q <= 32'h0;
      s_wr_q <= 1'b0;
    end else if (csr_go) begin
      s_sel_q <= map[2:0];
      s_f3_q <= f3;
      s_src_q <= f3[2] ? {27'h0, instr[19:15]} : rs1_data;
      s_wr_q <= csr_wr;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      priv_q <= pmc_pkg::RST_PRIV;
      prev_q <= pmc_pkg::RST_PRIV;
      epc_q <= pmc_pkg::EPC_RST;
    end else if (trap && !dbg_mode_q) begin
      prev_q <= priv_q;
      priv_q <= pmc_pkg::PRV_TOP;
      epc_q <= instr_pc;
    end else if (ret_top) begin
      priv_q <= prev_q;
      prev_q <= pmc_pkg::LOWEST_PRIV;
    end else if (ret_ker) begin
      priv_q <= pmc_pkg::PRV_APP;
    end else if (do_wr && s_sel_q == pmc_pkg::SEL_STATUS) begin
      // Saved level is legalised so a return never enters 10 or an
      // unbuilt level
      prev_q <= pmc_pkg::pmc_fix(
        new_val[pmc_pkg::STAT_PREV_HI:pmc_pkg::STAT_PREV_LO]);
    end else if (do_wr && s_sel_q == pmc_pkg::SEL_EPC) begin
      epc_q <= new_val;
    end
  end

  // Debug keeps the level it interrupted and returns to it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dbg_mode_q <= 1'b0;
      dpc_q <= pmc_pkg::EPC_RST;
    end else if (dbg_take) begin
      dbg_mode_q <= 1'b1;
      dpc_q <= instr_pc;
    end else if (ret_dbg) begin
      dbg_mode_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      exc_valid_q <= 1'b0;
      exc_cause_q <= 4'h0;
    end else begin
      exc_valid_q <= trap;
      if (trap) exc_cause_q <= cause;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      redirect_valid_q <= 1'b0;
      redirect_pc_q <= pmc_pkg::TRAP_VEC;
    end else begin
      redirect_valid_q <= (trap && !dbg_mode_q) || ret_top || ret_ker ||
                          ret_dbg;
      if (trap && !dbg_mode_q) redirect_pc_q <= pmc_pkg::TRAP_VEC;
      else if (ret_top || ret_ker) redirect_pc_q <= epc_q;
      else if (ret_dbg) redirect_pc_q <= dpc_q;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_valid_q <= 1'b0;
      rd_data_q <= 32'h0;
    end else begin
      rd_valid_q <= (state_q == pmc_pkg::ST_RMW);
      if (state_q == pmc_pkg::ST_RMW) rd_data_q <= old_val;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) cycle_q <= pmc_pkg::CYCLE_RST;
    else cycle_q <= cycle_q + 32'h1;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_priv_code_legal: assert property (priv_q != pmc_pkg::PRV_RSV)
    else $error("privilege level holds reserved code");
  a_level_combo_ok: assert property (pmc_pkg::pmc_legal(priv_q))
    else $error("privilege level not among built levels");
  a_bad_op_blocked: assert property (ill |=> exc_valid_q &&
      state_q == pmc_pkg::ST_IDLE && !rd_valid_q ##1 !rd_valid_q)
    else $error("refused operation took effect");
  a_top_full_access: assert property (go && is_csr && map[3] &&
      priv_q == pmc_pkg::PRV_TOP && !dbg_only && !csr_ro_wr
      |=> busy_q ##1 rd_valid_q)
    else $error("top tier denied a register");
  a_dbg_only_guard: assert property (go && is_csr && dbg_only &&
      !dbg_mode_q |=> exc_valid_q && exc_cause_q == pmc_pkg::CAUSE_ILLEGAL)
    else $error("debug-only register reached outside debug");
  a_higher_may_use: assert property (go && is_csr && map[3] &&
      priv_q > addr[9:8] && !csr_ro_wr && !dbg_only |=> !exc_valid_q)
    else $error("higher level refused a lower level register");
  a_rmw_atomic: assert property (csr_go |=> busy_q && !go
      ##1 rd_valid_q && !busy_q)
    else $error("register access not a closed two cycle step");
  a_app_trap_top: assert property (trap && !dbg_mode_q &&
      priv_q == pmc_pkg::PRV_APP |=> priv_q == pmc_pkg::PRV_TOP &&
      prev_q == pmc_pkg::PRV_APP && redirect_valid_q &&
      epc_q == $past(instr_pc))
    else $error("trap from app tier not taken to top");
  a_ro_write_ill: assert property (go && is_csr && csr_ro_wr
      |=> exc_valid_q && exc_cause_q == pmc_pkg::CAUSE_ILLEGAL)
    else $error("write to read-only register not refused");
  a_missing_ill: assert property (go && is_csr && !map[3]
      |=> exc_valid_q && exc_cause_q == pmc_pkg::CAUSE_ILLEGAL)
    else $error("missing register not refused");
  a_reset_top: assert property (@(posedge mclk) disable iff (1'b0)
      rst |=> priv_q == pmc_pkg::PRV_TOP && !dbg_mode_q)
    else $error("reset did not leave top tier");

  c_app_call: cover property (ecall && priv_q == pmc_pkg::PRV_APP);
  c_rmw_done: cover property (csr_go ##2 rd_valid_q);
  c_dbg_round: cover property (dbg_take ##[1:20] ret_dbg);
  c_drop_to_app: cover property (ret_top && prev_q == pmc_pkg::PRV_APP);
endmodule : pmc_priv_ctrl
`default_nettype wire

// ### pmc_pkg.sv
/*
  Constants, types and helper functions of the privilege mode control block.
  Assumes one core clock; the level combination and debug option are fixed
  here at build time.
*/
package pmc_pkg;

  localparam logic [1:0] PRV_APP = 2'h0;
  localparam logic [1:0] PRV_KER = 2'h1;
  localparam logic [1:0] PRV_RSV = 2'h2;
  localparam logic [1:0] PRV_TOP = 2'h3;
  localparam logic [1:0] RST_PRIV = PRV_TOP;

  localparam logic [1:0] CFG_TOP = 2'h0;
  localparam logic [1:0] CFG_TOP_APP = 2'h1;
  localparam logic [1:0] CFG_TOP_KER_APP = 2'h2;
  localparam logic [1:0] LVL_CFG = CFG_TOP_KER_APP;
  localparam logic DEBUG_IMPL = 1'b1;

  localparam logic [6:0] OPC_SYSTEM = 7'h73;
  localparam logic [2:0] F3_PRIV = 3'h0;
  localparam logic [2:0] F3_RSV = 3'h4;
  localparam logic [1:0] F3_LOW_RW = 2'h1;
  localparam logic [1:0] F3_LOW_RS = 2'h2;
  localparam logic [31:0] INS_ENV_CALL = 32'h00000073;
  localparam logic [31:0] INS_BREAK = 32'h00100073;
  localparam logic [31:0] INS_TOP_RET = 32'h30200073;
  localparam logic [31:0] INS_KER_RET = 32'h10200073;
  localparam logic [31:0] INS_WAIT = 32'h10500073;
  localparam logic [31:0] INS_DBG_RET = 32'h7b200073;

  localparam logic [11:0] CSR_APP_SCRATCH = 12'h040;
  localparam logic [11:0] CSR_KER_SCRATCH = 12'h140;
  localparam logic [11:0] CSR_TOP_STATUS = 12'h300;
  localparam logic [11:0] CSR_TOP_SCRATCH = 12'h340;
  localparam logic [11:0] CSR_TOP_EPC = 12'h341;
  localparam logic [11:0] CSR_DBG_SCRATCH = 12'h7b2;
  localparam logic [11:0] CSR_CYCLE = 12'hc00;
  localparam logic [11:0] CSR_HART_ID = 12'hf14;
  localparam logic [11:0] DBG_ONLY_LO = 12'h7b0;
  localparam logic [11:0] DBG_ONLY_HI = 12'h7bf;
  localparam logic [1:0] RO_CODE = 2'h3;
  localparam int STAT_PREV_LO = 11;
  localparam int STAT_PREV_HI = 12;
  // Value is arbitrary
  localparam logic [31:0] HART_ID_VAL = 32'h00000000;

  // Selector codes: 0..3 scratch store words, then fixed registers
  localparam logic [2:0] SEL_STATUS = 3'h4;
  localparam logic [2:0] SEL_EPC = 3'h5;
  localparam logic [2:0] SEL_CYCLE = 3'h6;
  localparam logic [2:0] SEL_HART = 3'h7;
  localparam int STORE_DEPTH = 4;
  localparam logic [31:0] STORE_RST = 32'h00000000;
  localparam logic [31:0] EPC_RST = 32'h00000000;
  localparam logic [31:0] CYCLE_RST = 32'h00000000;
  localparam logic [31:0] TRAP_VEC = 32'h00000100;

  localparam logic [3:0] CAUSE_ILLEGAL = 4'h2;
  localparam logic [3:0] CAUSE_BREAK = 4'h3;
  localparam logic [3:0] CAUSE_ECALL_BASE = 4'h8;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RMW = 2'b10
  } pmc_state_t;

  localparam logic [1:0] LOWEST_PRIV =
    (LVL_CFG == CFG_TOP) ? PRV_TOP : PRV_APP;

  function automatic logic pmc_legal(input logic [1:0] m);
    unique case (m)
      PRV_TOP: pmc_legal = 1'b1;
      PRV_APP: pmc_legal = (LVL_CFG != CFG_TOP);
      PRV_KER: pmc_legal = (LVL_CFG == CFG_TOP_KER_APP);
      PRV_RSV: pmc_legal = 1'b0;
    endcase
  endfunction : pmc_legal

  function automatic logic [1:0] pmc_fix(input logic [1:0] m);
    pmc_fix = pmc_legal(m) ? m : LOWEST_PRIV;
  endfunction : pmc_fix

endpackage : pmc_pkg

// ### pmc_csr_store.sv
/*
  Small scratch register store of the privilege block, one word per level.
  Read data come out of a register one cycle after the read strobe.
*/
`timescale 1ns/1ns
`default_nettype none
module pmc_csr_store (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Write port
  input wire logic wr_en,
  input wire logic [1:0] wr_idx,
  input wire logic [31:0] wr_data,
  // Read port
  input wire logic rd_en,
  input wire logic [1:0] rd_idx,
  output logic [31:0] rd_data
);
  logic [31:0] mem_q [pmc_pkg::STORE_DEPTH];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < pmc_pkg::STORE_DEPTH; i++) begin
        mem_q[i] <= pmc_pkg::STORE_RST;
      end
    end else if (wr_en) begin
      mem_q[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_data <= pmc_pkg::STORE_RST;
    end else if (rd_en) begin
      rd_data <= mem_q[rd_idx];
    end
  end
endmodule : pmc_csr_store
`default_nettype wire

// ### pmc_priv_ctrl_bench.sv
/*
  Self-checking bench of the privilege mode control block: reset values,
  table of instruction cases, then atomic access, trap, debug and mid-run reset tests.
  Assumes the package build choice: top, kernel and app levels, debug built.
*/
`timescale 1ns/1ns
`default_nettype none
module pmc_priv_ctrl_bench;
  localparam logic [1:0] K_NONE = 2'h0;
  localparam logic [1:0] K_EXC = 2'h1;
  localparam logic [1:0] K_CSR = 2'h2;
  localparam logic [1:0] K_RET = 2'h3;
  localparam int NR = 22;
  typedef struct {
    logic [1:0] lvl;
    logic [31:0] ins;
    logic [1:0] kind;
    logic [3:0] val;
  } pmc_row_t;
  // Clock and reset
  logic mclk = 1'b0;
  logic rst = 1'b1;
  // Instruction issue
  logic instr_valid = 1'b0;
  logic [31:0] instr = 32'h00000000;
  logic [31:0] instr_pc = 32'h00000000;
  logic [31:0] rs1_data = 32'h00000000;
  logic dbg_req = 1'b0;
  // Outputs
  logic [1:0] priv_q;
  logic dbg_mode_q, busy_q, exc_valid_q, redirect_valid_q, rd_valid_q;
  logic [3:0] exc_cause_q;
  logic [31:0] redirect_pc_q, rd_data_q;
  int err_total = 0;
  int compares = 0;
  pmc_row_t rows [NR];

  pmc_priv_ctrl dut (.mclk(mclk), .rst(rst), .instr_valid(instr_valid),
    .instr(instr), .instr_pc(instr_pc), .rs1_data(rs1_data),
    .dbg_req(dbg_req), .priv_q(priv_q), .dbg_mode_q(dbg_mode_q),
    .busy_q(busy_q), .exc_valid_q(exc_valid_q), .exc_cause_q(exc_cause_q),
    .redirect_valid_q(redirect_valid_q), .redirect_pc_q(redirect_pc_q),
    .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q));

  always #5 mclk = ~mclk;

  // Reserved level must never appear
  always @(posedge mclk) begin
    if (priv_q === pmc_pkg::PRV_RSV) begin
      err_total = err_total + 1;
      $display("mismatch priv_q expected legal level seen %h", priv_q);
    end
  end

  function automatic logic [31:0] csr_op(input logic [2:0] f3,
    input logic [11:0] a, input logic [4:0] s);
    csr_op = {a, s, f3, 5'h01, 7'h73};
  endfunction : csr_op

  task automatic chk_bit(input string n, input logic e, input logic s);
    compares = compares + 1;
    if (s !== e) begin
      err_total = err_total + 1;
      $display("mismatch %s expected %b seen %b", n, e, s);
    end
  endtask : chk_bit

  task automatic chk_lvl(input string n, input logic [1:0] e,
    input logic [1:0] s);
    compares = compares + 1;
    if (s !== e) begin
      err_total = err_total + 1;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk_lvl

  task automatic chk_cause(input logic [3:0] e);
    compares = compares + 1;
    if (exc_cause_q !== e) begin
      err_total = err_total + 1;
      $display("mismatch cause expected %h seen %h", e, exc_cause_q);
    end
  endtask : chk_cause

  task automatic chk_word(input string n, input logic [31:0] e,
    input logic [31:0] s);
    compares = compares + 1;
    if (s !== e) begin
      err_total = err_total + 1;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk_word

  task automatic step;
    @(posedge mclk);
    #1;
  endtask : step

  // Offer one instruction for one edge; results of that edge then show
  task automatic issue(input logic [31:0] ins, input logic [31:0] r,
    input logic [31:0] pc);
    instr_valid = 1'b1;
    instr = ins;
    rs1_data = r;
    instr_pc = pc;
    step();
    instr_valid = 1'b0;
  endtask : issue

  // Trap to top, plant the saved level, then return into it
  task automatic set_level(input logic [1:0] l);
    issue(pmc_pkg::INS_ENV_CALL, 32'h0, 32'h0);
    issue(csr_op(3'h1, pmc_pkg::CSR_TOP_STATUS, 5'h02),
      {19'h0, l, 11'h0}, 32'h0);
    step();
    issue(pmc_pkg::INS_TOP_RET, 32'h0, 32'h0);
  endtask : set_level

  task automatic stop_test;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  initial begin
    rows = '{
      '{pmc_pkg::PRV_APP, csr_op(3'h1, 12'h040, 5'h02), K_CSR, 4'h0},
      '{pmc_pkg::PRV_APP, csr_op(3'h1, 12'h140, 5'h02), K_EXC, 4'h2},
      '{pmc_pkg::PRV_KER, csr_op(3'h1, 12'h140, 5'h02), K_CSR, 4'h0},
      '{pmc_pkg::PRV_KER, csr_op(3'h1, 12'h040, 5'h02), K_CSR, 4'h0},
      '{pmc_pkg::PRV_KER, csr_op(3'h1, 12'h340, 5'h02), K_EXC, 4'h2},
      '{pmc_pkg::PRV_TOP, csr_op(3'h5, 12'h040, 5'h02), K_CSR, 4'h0},
      '{pmc_pkg::PRV_TOP, csr_op(3'h1, 12'h7b2, 5'h02), K_EXC, 4'h2},
      '{pmc_pkg::PRV_TOP, csr_op(3'h2, 12'hc00, 5'h00), K_CSR, 4'h0},
      '{pmc_pkg::PRV_TOP, csr_op(3'h1, 12'hc00, 5'h02), K_EXC, 4'h2},
      '{pmc_pkg::PRV_TOP, csr_op(3'h3, 12'hf14, 5'h02), K_EXC, 4'h2},
      '{pmc_pkg::PRV_TOP, csr_op(3'h6, 12'h123, 5'h02), K_EXC, 4'h2},
      '{pmc_pkg::PRV_APP, pmc_pkg::INS_ENV_CALL, K_EXC, 4'h8},
      '{pmc_pkg::PRV_KER, pmc_pkg::INS_ENV_CALL, K_EXC, 4'h9},
      '{pmc_pkg::PRV_TOP, pmc_pkg::INS_ENV_CALL, K_EXC, 4'hb},
      '{pmc_pkg::PRV_APP, pmc_pkg::INS_BREAK, K_EXC, 4'h3},
      '{pmc_pkg::PRV_APP, pmc_pkg::INS_TOP_RET, K_EXC, 4'h2},
      '{pmc_pkg::PRV_APP, pmc_pkg::INS_KER_RET, K_EXC, 4'h2},
      '{pmc_pkg::PRV_KER, pmc_pkg::INS_TOP_RET, K_EXC, 4'h2},
      '{pmc_pkg::PRV_APP, pmc_pkg::INS_WAIT, K_EXC, 4'h2},
      '{pmc_pkg::PRV_TOP, pmc_pkg::INS_WAIT, K_NONE, 4'h0},
      '{pmc_pkg::PRV_KER, pmc_pkg::INS_KER_RET, K_RET, 4'h0},
      '{pmc_pkg::PRV_APP, csr_op(3'h1, 12'h040, 5'h02) ^ 32'h40, K_NONE, 4'h0}
    };
    // Reset values
    repeat (16) @(posedge mclk);
    chk_lvl("priv_rst", pmc_pkg::PRV_TOP, priv_q);
    chk_bit("dbg_rst", 1'b0, dbg_mode_q);
    chk_word("pc_rst", pmc_pkg::TRAP_VEC, redirect_pc_q);
    #1;
    rst = 1'b0;
    step();
    chk_lvl("priv_rel", pmc_pkg::PRV_TOP, priv_q);
    for (int i = 0; i < NR; i++) begin
      set_level(rows[i].lvl);
      issue(rows[i].ins, 32'h0, 32'h0);
      chk_bit("exc", rows[i].kind == K_EXC, exc_valid_q);
      if (rows[i].kind == K_EXC) begin
        chk_cause(rows[i].val);
        chk_lvl("trap_lvl", pmc_pkg::PRV_TOP, priv_q);
        chk_word("trap_pc", pmc_pkg::TRAP_VEC, redirect_pc_q);
      end
      chk_bit("redir", rows[i].kind[0], redirect_valid_q);
      if (rows[i].kind == K_RET) begin
        chk_lvl("ret_lvl", rows[i].val[1:0], priv_q);
      end
      step();
      chk_bit("rd", rows[i].kind == K_CSR, rd_valid_q);
    end
    // Atomic access at top; an offer in the modify cycle is ignored
    set_level(pmc_pkg::PRV_TOP);
    instr_valid = 1'b1;
    instr = csr_op(3'h1, 12'h340, 5'h02);
    rs1_data = 32'h000000a5;
    instr_pc = 32'h0;
    step();
    chk_bit("busy", 1'b1, busy_q);
    instr = pmc_pkg::INS_ENV_CALL;
    step();
    instr_valid = 1'b0;
    chk_bit("refused", 1'b0, exc_valid_q);
    issue(csr_op(3'h1, 12'h340, 5'h02), 32'h0000005a, 32'h0);
    step();
    chk_word("old_a5", 32'h000000a5, rd_data_q);
    issue(csr_op(3'h2, 12'h340, 5'h00), 32'hffffffff, 32'h0);
    step();
    chk_word("old_5a", 32'h0000005a, rd_data_q);
    // Immediate clear of bits 1 and 3
    issue(csr_op(3'h7, 12'h340, 5'h0a), 32'h0, 32'h0);
    step();
    issue(csr_op(3'h2, 12'h340, 5'h00), 32'h0, 32'h0);
    step();
    chk_word("old_50", 32'h00000050, rd_data_q);
    // Reserved saved level is legalised
    issue(csr_op(3'h1, 12'h300, 5'h02), 32'h00001000, 32'h0);
    step();
    issue(csr_op(3'h2, 12'h300, 5'h00), 32'h0, 32'h0);
    step();
    chk_word("status", 32'h00000000, rd_data_q);
    // Trap from app and resume at saved point
    set_level(pmc_pkg::PRV_APP);
    issue(pmc_pkg::INS_ENV_CALL, 32'h0, 32'h00002000);
    chk_lvl("ecall_lvl", pmc_pkg::PRV_TOP, priv_q);
    issue(csr_op(3'h2, 12'h341, 5'h00), 32'h0, 32'h0);
    step();
    chk_word("epc", 32'h00002000, rd_data_q);
    // Handler steps the saved point past the call
    issue(csr_op(3'h1, 12'h341, 5'h02), 32'h00002400, 32'h0);
    step();
    issue(pmc_pkg::INS_TOP_RET, 32'h0, 32'h0);
    chk_word("ret_pc", 32'h00002400, redirect_pc_q);
    chk_lvl("ret_app", pmc_pkg::PRV_APP, priv_q);
    // Debug entry beats a simultaneous instruction
    set_level(pmc_pkg::PRV_TOP);
    dbg_req = 1'b1;
    issue(pmc_pkg::INS_ENV_CALL, 32'h0, 32'h00003000);
    dbg_req = 1'b0;
    chk_bit("dbg_in", 1'b1, dbg_mode_q);
    chk_bit("dbg_exc", 1'b0, exc_valid_q);
    issue(csr_op(3'h1, 12'h7b2, 5'h02), 32'h0, 32'h0);
    chk_bit("dbg_csr", 1'b0, exc_valid_q);
    step();
    issue(csr_op(3'h1, 12'h123, 5'h02), 32'h0, 32'h0);
    chk_bit("dbg_bad", 1'b1, exc_valid_q);
    chk_bit("dbg_stay", 1'b1, dbg_mode_q);
    chk_bit("dbg_nored", 1'b0, redirect_valid_q);
    issue(pmc_pkg::INS_DBG_RET, 32'h0, 32'h0);
    chk_bit("dbg_out", 1'b0, dbg_mode_q);
    chk_word("dpc", 32'h00003000, redirect_pc_q);
    // Reset in mid-run from the app tier
    set_level(pmc_pkg::PRV_APP);
    rst = 1'b1;
    step();
    chk_lvl("priv_mid", pmc_pkg::PRV_TOP, priv_q);
    rst = 1'b0;
    step();
    chk_lvl("priv_after", pmc_pkg::PRV_TOP, priv_q);
    stop_test();
  end
endmodule : pmc_priv_ctrl_bench
`default_nettype wire
